// [tdt_timer.sv]
// two-channel 16-bit down timer with APB register bank
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module tdt_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic slow_clock,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic timer_irq,
   output logic [1:0] chan_running_status
);
   import tdt_pkg::*;

   tdt_state_s s_q;
   tdt_state_s s_d;
   logic [1:0] run_set;
   logic [1:0] run_clr;
   logic [5:0] flag_set;
   logic wr;
   logic rd;
   logic soft_reset_cmd;
   logic slow_tick;

   function automatic logic [31:0] setup_word(input tdt_chan_s c);
      setup_word = '0;
      setup_word[TDT_PRESC_LSB +: 4] = c.presc;
      setup_word[TDT_SEL_BIT] = c.sel;
      setup_word[TDT_RELOAD_BIT] = c.reload;
      setup_word[TDT_CORE_CLOCK_DIVIDER_FIELD_LSB +: TDT_CORE_CLOCK_DIVIDER_FIELD_W] = c.core_clock_divider_field;
   endfunction

   function automatic tdt_chan_s chan_reset();
      chan_reset = '0;
      chan_reset.st = TDT_IDLE;
   endfunction

   assign wr = psel && penable && pwrite && !s_q.pready;
   assign rd = psel && !penable && !pwrite;
   assign soft_reset_cmd = wr && paddr == TDT_CMD_OFS && pwdata[TDT_SOFT_RESET_CMD_BIT];
   // slow clock edge detected after two-flop synchroniser
   assign slow_tick = s_q.lf_s2 && !s_q.lf_s3;

   always_comb begin
      logic div_tick;
      logic cnt_tick;
      div_tick = 1'b0;
      cnt_tick = 1'b0;
      s_d = s_q;
      run_set = '0;
      run_clr = '0;
      flag_set = '0;
      s_d.lf_s1 = slow_clock;
      s_d.lf_s2 = s_q.lf_s1;
      s_d.lf_s3 = s_q.lf_s2;
      s_d.pready = psel && penable && !s_q.pready;
      if (wr) begin
         case (paddr)
            TDT_CMD_OFS: begin
               run_set[0] = pwdata[TDT_RUN0_BIT];
               run_set[1] = pwdata[TDT_RUN1_BIT];
               run_clr[0] = pwdata[TDT_STOP0_BIT];
               run_clr[1] = pwdata[TDT_STOP1_BIT];
            end
            TDT_ECR_OFS: if (pwdata[TDT_PMSR_BIT]) s_d.pm_clk = 1'b1;
            TDT_DCR_OFS: if (pwdata[TDT_PMSR_BIT]) s_d.pm_clk = 1'b0;
            TDT_CLR_OFS: s_d.flags = s_q.flags & ~pwdata[5:0];
            TDT_IEN_OFS: s_d.mask = s_q.mask | pwdata[5:0];
            TDT_IDIS_OFS: s_d.mask = s_q.mask & ~pwdata[5:0];
            default: ;
         endcase
         for (int i = 0; i < 2; i++) begin
            if (paddr == (i == 0 ? TDT_SETUP0_OFS : TDT_SETUP1_OFS) && !s_q.ch[i].run) begin
               s_d.ch[i].presc = pwdata[TDT_PRESC_LSB +: 4];
               s_d.ch[i].sel = pwdata[TDT_SEL_BIT];
               s_d.ch[i].reload = pwdata[TDT_RELOAD_BIT];
               s_d.ch[i].core_clock_divider_field = pwdata[TDT_CORE_CLOCK_DIVIDER_FIELD_LSB +: TDT_CORE_CLOCK_DIVIDER_FIELD_W];
            end
            if (paddr == (i == 0 ? TDT_PRELOAD0_OFS : TDT_PRELOAD1_OFS) && !s_q.ch[i].run) begin
               s_d.ch[i].preload = pwdata[15:0];
               s_d.ch[i].st = TDT_IDLE;
               s_d.ch[i].count = pwdata[15:0];
            end
         end
      end
      for (int i = 0; i < 2; i++) begin
         s_d.ch[i].end_pipe = {s_q.ch[i].end_pipe[1:0], 1'b0};
         if (run_clr[i]) begin
            s_d.ch[i].run = 1'b0;
            s_d.ch[i].div_cnt = '0;
            s_d.ch[i].pre_cnt = '0;
            if (s_q.ch[i].run) flag_set[i*TDT_FLAGS_PER_CH + TDT_DIS_BIT] = 1'b1;
            if (s_q.ch[i].st == TDT_LOAD) s_d.ch[i].st = TDT_RUN;
         end else if (run_set[i] && !s_q.ch[i].run) begin
            s_d.ch[i].run = 1'b1;
            s_d.ch[i].div_cnt = '0;
            s_d.ch[i].pre_cnt = '0;
            if (s_q.ch[i].st == TDT_IDLE) begin
               s_d.ch[i].count = s_q.ch[i].preload;
            end
            s_d.ch[i].st = TDT_LOAD;
         end else if (s_q.ch[i].run) begin
            case (s_q.ch[i].st)
               TDT_LOAD: begin
                  s_d.ch[i].st = TDT_RUN;
                  flag_set[i*TDT_FLAGS_PER_CH + TDT_LD_BIT] = 1'b1;
               end
               TDT_RUN: begin
                  div_tick = 1'b0;
                  cnt_tick = 1'b0;
                  if (s_q.ch[i].sel) begin
                     div_tick = slow_tick;
                  end else if (s_q.ch[i].div_cnt == {s_q.ch[i].core_clock_divider_field[9:0], 1'b1}) begin
                     div_tick = 1'b1;
                     s_d.ch[i].div_cnt = '0;
                  end else begin
                     s_d.ch[i].div_cnt = s_q.ch[i].div_cnt + 11'h001;
                  end
                  if (div_tick) begin
                     if (s_q.ch[i].pre_cnt == 16'((32'h1 << s_q.ch[i].presc) - 32'h1)) begin
                        cnt_tick = 1'b1;
                        s_d.ch[i].pre_cnt = '0;
                     end else begin
                        s_d.ch[i].pre_cnt = s_q.ch[i].pre_cnt + 16'h0001;
                     end
                  end
                  if (cnt_tick && s_q.ch[i].count != 16'h0000) begin
                     s_d.ch[i].count = s_q.ch[i].count - 16'h0001;
                     if (s_q.ch[i].count == 16'h0001) begin
                        s_d.ch[i].end_pipe[0] = 1'b1;
                        if (s_q.ch[i].reload) begin
                           s_d.ch[i].count = s_q.ch[i].preload;
                        end else begin
                           s_d.ch[i].run = 1'b0;
                           s_d.ch[i].st = TDT_IDLE;
                        end
                     end
                  end
               end
               default: s_d.ch[i].st = TDT_IDLE;
            endcase
         end
         if (s_q.ch[i].end_pipe[TDT_END_DELAY - 1]) flag_set[i*TDT_FLAGS_PER_CH + TDT_DONE_BIT] = 1'b1;
      end
      s_d.flags = s_d.flags | flag_set;
      s_d.irq = |(s_d.flags & s_d.mask);
      if (rd) begin
         case (paddr)
            TDT_PMSR_OFS: s_d.prdata = 32'(s_q.pm_clk) << TDT_PMSR_BIT;
            TDT_STAT_OFS: s_d.prdata = {6'h00, s_q.ch[1].run, s_q.ch[0].run, 18'h00000, s_q.flags};
            TDT_MASK_OFS: s_d.prdata = {26'h0000000, s_q.mask};
            TDT_SETUP0_OFS: s_d.prdata = setup_word(s_q.ch[0]);
            TDT_SETUP1_OFS: s_d.prdata = setup_word(s_q.ch[1]);
            TDT_PRELOAD0_OFS: s_d.prdata = {16'h0000, s_q.ch[0].preload};
            TDT_PRELOAD1_OFS: s_d.prdata = {16'h0000, s_q.ch[1].preload};
            TDT_CCV0_OFS: s_d.prdata = {16'h0000, s_q.ch[0].count};
            TDT_CCV1_OFS: s_d.prdata = {16'h0000, s_q.ch[1].count};
            default: s_d.prdata = TDT_RESET_WORD;
         endcase
      end
      if (soft_reset_cmd) begin
         s_d.ch[0] = chan_reset();
         s_d.ch[1] = chan_reset();
         s_d.flags = '0;
         s_d.mask = '0;
         s_d.irq = 1'b0;
         s_d.pm_clk = s_q.pm_clk;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ch[0].st <= TDT_IDLE;
         s_q.ch[1].st <= TDT_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = 1'b0;
   assign timer_irq = s_q.irq;
   assign chan_running_status = {s_q.ch[1].run, s_q.ch[0].run};
endmodule

// [tdt_pkg.sv]
// register map, field layout and state types of the two-channel down timer
package tdt_pkg;
   localparam logic [11:0] TDT_PMSR_OFS = 12'h058;
   localparam logic [11:0] TDT_ECR_OFS = 12'h050;
   localparam logic [11:0] TDT_DCR_OFS = 12'h054;
   localparam logic [11:0] TDT_CMD_OFS = 12'h060;
   localparam logic [11:0] TDT_CLR_OFS = 12'h06c;
   localparam logic [11:0] TDT_STAT_OFS = 12'h070;
   localparam logic [11:0] TDT_IEN_OFS = 12'h074;
   localparam logic [11:0] TDT_IDIS_OFS = 12'h078;
   localparam logic [11:0] TDT_MASK_OFS = 12'h07c;
   localparam logic [11:0] TDT_SETUP0_OFS = 12'h080;
   localparam logic [11:0] TDT_PRELOAD0_OFS = 12'h084;
   localparam logic [11:0] TDT_SETUP1_OFS = 12'h088;
   localparam logic [11:0] TDT_PRELOAD1_OFS = 12'h08c;
   localparam logic [11:0] TDT_CCV0_OFS = 12'h200;
   localparam logic [11:0] TDT_CCV1_OFS = 12'h204;
   localparam int TDT_PMSR_BIT = 1;
   localparam int TDT_SOFT_RESET_CMD_BIT = 0;
   localparam int TDT_RUN0_BIT = 1;
   localparam int TDT_STOP0_BIT = 2;
   localparam int TDT_RUN1_BIT = 3;
   localparam int TDT_STOP1_BIT = 4;
   localparam int TDT_FLAGS_PER_CH = 3;
   localparam int TDT_DONE_BIT = 0;
   localparam int TDT_DIS_BIT = 1;
   localparam int TDT_LD_BIT = 2;
   localparam int TDT_RUNNING_BIT = 24;
   localparam int TDT_PRESC_LSB = 0;
   localparam int TDT_SEL_BIT = 4;
   localparam int TDT_RELOAD_BIT = 5;
   localparam int TDT_CORE_CLOCK_DIVIDER_FIELD_LSB = 8;
   localparam int TDT_CORE_CLOCK_DIVIDER_FIELD_W = 11;
   localparam int TDT_END_DELAY = 3;
   localparam logic [31:0] TDT_RESET_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      TDT_IDLE = 3'b001,
      TDT_LOAD = 3'b010,
      TDT_RUN = 3'b100
   } tdt_chst_e;

   typedef struct packed {
      tdt_chst_e st;
      logic run;
      logic [15:0] preload;
      logic [15:0] count;
      logic [3:0] presc;
      logic sel;
      logic reload;
      logic [10:0] core_clock_divider_field;
      logic [10:0] div_cnt;
      logic [15:0] pre_cnt;
      logic [2:0] end_pipe;
   } tdt_chan_s;

   typedef struct packed {
      tdt_chan_s [1:0] ch;
      logic [5:0] flags;
      logic [5:0] mask;
      logic pm_clk;
      logic irq;
      logic pready;
      logic [31:0] prdata;
      logic lf_s1;
      logic lf_s2;
      logic lf_s3;
   } tdt_state_s;
endpackage

// [tdt_timer_sva.sv]
// port checks for the two-channel down timer
`timescale 1ns/1ps
module tdt_timer_sva
   import tdt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic slow_clock,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_irq,
   input wire logic [1:0] chan_running_status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence wr_to(logic [11:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   sequence setup_cyc;
      psel && !penable;
   endsequence
   chk_ready_wait: assert property (setup_cyc |=> !pready ##1 pready) else $error("ready timing");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   chk_no_slverr: assert property (!pslverr) else $error("slave error");
   chk_run_starts: assert property (wr_to(TDT_CMD_OFS) ##0 pwdata[1] && !pwdata[2] && !pwdata[0]
      |-> ##2 chan_running_status[0]) else $error("run lost");
   chk_stop0_wins: assert property (wr_to(TDT_CMD_OFS) ##0 pwdata[TDT_STOP0_BIT]
      |-> ##2 !chan_running_status[0]) else $error("stop0 lost");
   chk_stop1_wins: assert property (wr_to(TDT_CMD_OFS) ##0 pwdata[TDT_STOP1_BIT]
      |-> ##2 !chan_running_status[1]) else $error("stop1 lost");
   chk_soft_clear: assert property (wr_to(TDT_CMD_OFS) ##0 pwdata[TDT_SOFT_RESET_CMD_BIT]
      |-> ##2 chan_running_status == 2'b00 && !timer_irq) else $error("soft reset");
   chk_irq_masked: assert property (wr_to(TDT_IDIS_OFS) ##0 pwdata[5:0] == 6'h3f
      |-> ##2 !timer_irq) else $error("irq unmasked");
endmodule
bind tdt_timer tdt_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .slow_clock(slow_clock), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq), .chan_running_status(chan_running_status));

// [tb.sv]
// self-checking bench for the two-channel down timer
`timescale 1ns/1ps
module tb;
   import tdt_pkg::*;
   typedef struct packed {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} tdt_row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow_clock = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, h;
   logic pready, pslverr, timer_irq;
   logic [1:0] chan_running_status;
   logic [2:0] slow_cnt = 3'h0;
   int bad_count = 0;
   int checked = 0;
   tdt_row_s rows [6] = '{'{12'h100, 32'hffffffff, 12'h100, 32'h0},
      '{TDT_SETUP0_OFS, 32'hffffffff, TDT_SETUP0_OFS, 32'h0007ff3f},
      '{TDT_PRELOAD0_OFS, 32'hffffffff, TDT_PRELOAD0_OFS, 32'h0000ffff},
      '{TDT_STAT_OFS, 32'hffffffff, TDT_STAT_OFS, 32'h0},
      '{TDT_IEN_OFS, 32'h15, TDT_MASK_OFS, 32'h15}, '{TDT_IDIS_OFS, 32'h05, TDT_MASK_OFS, 32'h10}};
   tdt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .slow_clock(slow_clock), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_irq(timer_irq), .chan_running_status(chan_running_status));
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      slow_cnt <= slow_cnt + 3'h1;
      slow_clock <= slow_cnt[2];
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (timer_irq !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (timer_irq !== 1'b1) begin
         bad_count++;
         wrap_up();
      end
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rdc(rows[i].ra, 32'hffffffff, rows[i].ex);
      end
      wr(TDT_SETUP0_OFS, 32'h0);
      wr(TDT_PRELOAD0_OFS, 32'h14);
      wr(TDT_IDIS_OFS, 32'h3f);
      wr(TDT_IEN_OFS, 32'h9);
      wr(TDT_CMD_OFS, 32'h2);
      rdc(TDT_STAT_OFS, 32'h01000000, 32'h01000000);
      wr(TDT_PRELOAD0_OFS, 32'h9);
      wr(TDT_SETUP0_OFS, 32'h1f);
      rdc(TDT_PRELOAD0_OFS, 32'hffffffff, 32'h14);
      rdc(TDT_SETUP0_OFS, 32'hffffffff, 32'h0);
      wait_irq();
      rdc(TDT_STAT_OFS, 32'h01000005, 32'h5);
      wr(TDT_CLR_OFS, 32'h1);
      rdc(TDT_STAT_OFS, 32'h1, 32'h0);
      chk(timer_irq, 32'h0);
      wr(TDT_PRELOAD0_OFS, 32'h3e8);
      wr(TDT_CMD_OFS, 32'h2);
      repeat (40) @(posedge pclk);
      wr(TDT_CMD_OFS, 32'h6);
      rdc(TDT_STAT_OFS, 32'h01000002, 32'h2);
      rdc(TDT_CCV0_OFS, 32'h0, 32'h0);
      h = r;
      chk(h > 32'd960 && h < 32'd990, 32'h1);
      repeat (10) @(posedge pclk);
      rdc(TDT_CCV0_OFS, 32'hffffffff, h);
      wr(TDT_CMD_OFS, 32'h2);
      repeat (20) @(posedge pclk);
      rdc(TDT_CCV0_OFS, 32'h0, 32'h0);
      chk(r < h, 32'h1);
      wr(TDT_CMD_OFS, 32'h4);
      wr(TDT_SETUP1_OFS, 32'h31);
      wr(TDT_PRELOAD1_OFS, 32'h3);
      wr(TDT_CMD_OFS, 32'h8);
      wait_irq();
      wr(TDT_CLR_OFS, 32'h8);
      rdc(TDT_STAT_OFS, 32'h02000008, 32'h02000000);
      wait_irq();
      wr(TDT_CMD_OFS, 32'h18);
      rdc(TDT_STAT_OFS, 32'h02000000, 32'h0);
      wr(TDT_ECR_OFS, 32'h2);
      wr(TDT_CMD_OFS, 32'h1);
      rdc(TDT_PMSR_OFS, 32'hffffffff, 32'h2);
      rdc(TDT_MASK_OFS, 32'hffffffff, 32'h0);
      rdc(TDT_SETUP1_OFS, 32'hffffffff, 32'h0);
      rdc(TDT_STAT_OFS, 32'hffffffff, 32'h0);
      wrap_up();
   end
endmodule
